// ===== include/ccr_pkg.sv
// Purpose: Shared constants for the conversion configuration register group.
// Assumes: APB with 32-bit data; each register index maps to byte address index*4.
// Notes: Register indices are kept as printed; byte addresses are derived.
package ccr_pkg;
  // Channel count and data widths
  localparam int CCR_NCH = 8;
  localparam int CCR_DW = 16;
  localparam int CCR_AW = 12;
  localparam int CCR_ACCW = 32;
  localparam int CCR_CNTW = 17;

  // Register indices
  localparam logic [9:0] CCR_IDX_AVG = 10'h027;
  localparam logic [9:0] CCR_IDX_RANGING = 10'h028;
  localparam logic [9:0] CCR_IDX_DOZE = 10'h029;
  localparam logic [9:0] CCR_IDX_SPAN = 10'h02A;

  // Field positions
  localparam int CCR_AVG_ON_BIT = 7;
  localparam int CCR_CODE_LSB = 0;
  localparam int CCR_CODE_W = 4;

  // Reset values
  localparam logic CCR_RST_AVG_ON = 1'h0;
  localparam logic [3:0] CCR_RST_AVG_CODE = 4'h0;
  localparam logic [7:0] CCR_RST_RANGING = 8'hFF;
  localparam logic [7:0] CCR_RST_DOZE = 8'h00;
  localparam logic [3:0] CCR_RST_SPAN = 4'hF;

  // Span limits in millivolts, indexed by code bits 3:1
  localparam logic [7:0][15:0] CCR_SPAN_MV = {
    16'h9C40, 16'h61A8, 16'h4E20, 16'h30D4,
    16'h2710, 16'h186A, 16'h1388, 16'h09C4
  };
endpackage : ccr_pkg

// ===== src/ccr_top.sv
// Purpose: Conversion configuration registers with per-channel averaging, sleep gating and span decode.
// Assumes: Converter requests and results arrive on pclk; zero-wait APB slave.
// Notes: All state lives in one struct; clk_en low freezes everything and stalls the bus.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - Bit 7 of the averaging control register turns oversampling on when one and off when zero, reset zero.
// - With oversampling on, ratio code n in bits 3 to 0 averages 2 to the power n+1 results.
// - Averaging runs separately for every channel on that channel's own results.
// - The auto ranging register holds one enable per channel, bit n for channel n, reset 0xFF.
// - The channel doze register holds one sleep bit per channel, bit n for channel n, reset 0x00.
// - A dozing channel ignores every conversion request while the others convert normally.
// - The channel 0 span register uses bits 3 to 0, resets to 0xF, and bits 7 to 4 are reserved.
// - Even span codes are unipolar, odd bipolar, and code pairs step the limit from 2.5 V to 40 V.
// - The averaging control register sits at 0x27 with reserved bits 6 to 4 and resets to zero.
module ccr_top
  import ccr_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CCR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Conversion requests and results
  input wire logic conv_req,
  input wire logic [CCR_NCH-1:0] result_valid,
  input wire logic [CCR_NCH-1:0][CCR_DW-1:0] result_data,
  output logic [CCR_NCH-1:0] chan_start,
  // Averaged output per channel
  output logic [CCR_NCH-1:0] avg_valid,
  output logic [CCR_NCH-1:0][CCR_DW-1:0] avg_data,
  // Settings toward the front end
  output logic averaging_on,
  output logic [3:0] average_count_code,
  output logic [CCR_NCH-1:0] automatic_gain_ranging,
  output logic [CCR_NCH-1:0] chan_doze,
  output logic [3:0] span_code,
  output logic span_bipolar,
  output logic [15:0] span_limit_mv
);

  typedef struct packed {
    logic avg_on;
    logic [3:0] avg_code;
    logic [7:0] ranging;
    logic [7:0] doze;
    logic [3:0] span;
    logic span_bip;
    logic [15:0] span_mv;
    logic [31:0] rdata;
    logic [CCR_NCH-1:0] start;
    logic [CCR_NCH-1:0] avg_vld;
    logic [CCR_NCH-1:0][CCR_DW-1:0] avg_out;
    logic [CCR_NCH-1:0][CCR_ACCW-1:0] acc;
    logic [CCR_NCH-1:0][CCR_CNTW-1:0] cnt;
  } ccr_state_s;

  ccr_state_s st_reg;
  ccr_state_s st_next;

  logic [9:0] idx;
  logic hit_avg;
  logic hit_rng;
  logic hit_doze;
  logic hit_span;
  logic mapped;
  logic wr_en;
  logic setup;
  logic [CCR_CNTW-1:0] target;
  logic [4:0] shift;

  // Address decode on word index
  assign idx = paddr[CCR_AW-1:2];
  assign hit_avg = (idx == CCR_IDX_AVG);
  assign hit_rng = (idx == CCR_IDX_RANGING);
  assign hit_doze = (idx == CCR_IDX_DOZE);
  assign hit_span = (idx == CCR_IDX_SPAN);
  assign mapped = hit_avg | hit_rng | hit_doze | hit_span;
  assign setup = psel & ~penable & clk_en;
  assign wr_en = psel & penable & pwrite & clk_en;

  // Averaging length: 2^(code+1) results
  assign shift = 5'(st_reg.avg_code) + 5'h01;
  assign target = CCR_CNTW'(1) << shift;

  // Bus handshake: never completes while frozen
  assign pready = clk_en;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = st_reg.rdata;

  // Next-state logic
  always_comb begin
    logic [CCR_ACCW-1:0] sum;
    sum = '0;
    st_next = st_reg;
    st_next.start = '0;
    st_next.avg_vld = '0;

    // Read data captured in the setup phase
    if (setup) begin
      st_next.rdata = '0;
      if (hit_avg) begin
        st_next.rdata[CCR_AVG_ON_BIT] = st_reg.avg_on;
        st_next.rdata[CCR_CODE_LSB +: CCR_CODE_W] = st_reg.avg_code;
      end
      if (hit_rng) begin
        st_next.rdata[7:0] = st_reg.ranging;
      end
      if (hit_doze) begin
        st_next.rdata[7:0] = st_reg.doze;
      end
      if (hit_span) begin
        st_next.rdata[3:0] = st_reg.span;
      end
    end

    // Register writes; reserved bits are dropped
    if (wr_en && hit_avg) begin
      st_next.avg_on = pwdata[CCR_AVG_ON_BIT];
      st_next.avg_code = pwdata[CCR_CODE_LSB +: CCR_CODE_W];
    end
    if (wr_en && hit_rng) begin
      st_next.ranging = pwdata[7:0];
    end
    if (wr_en && hit_doze) begin
      st_next.doze = pwdata[7:0];
    end
    if (wr_en && hit_span) begin
      st_next.span = pwdata[3:0];
    end

    // Span decode: low bit selects polarity, upper bits the limit
    st_next.span_bip = st_next.span[0];
    st_next.span_mv = CCR_SPAN_MV[st_next.span[3:1]];

    // Per-channel request gating and averaging
    for (int i = 0; i < CCR_NCH; i++) begin
      st_next.start[i] = conv_req & ~st_reg.doze[i];
      sum = st_reg.acc[i] + CCR_ACCW'(result_data[i]);
      if (!st_reg.avg_on) begin
        // Pass-through mode
        st_next.acc[i] = '0;
        st_next.cnt[i] = '0;
        if (result_valid[i]) begin
          st_next.avg_vld[i] = 1'b1;
          st_next.avg_out[i] = result_data[i];
        end
      end else if (result_valid[i]) begin
        if (st_reg.cnt[i] + CCR_CNTW'(1) == target) begin
          st_next.avg_vld[i] = 1'b1;
          st_next.avg_out[i] = CCR_DW'(sum >> shift);
          st_next.acc[i] = '0;
          st_next.cnt[i] = '0;
        end else begin
          st_next.acc[i] = sum;
          st_next.cnt[i] = st_reg.cnt[i] + CCR_CNTW'(1);
        end
      end
    end

    // Leaving averaging mode or rewriting the ratio restarts every series
    if (wr_en && hit_avg) begin
      st_next.acc = '0;
      st_next.cnt = '0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.avg_on <= CCR_RST_AVG_ON;
      st_reg.avg_code <= CCR_RST_AVG_CODE;
      st_reg.ranging <= CCR_RST_RANGING;
      st_reg.doze <= CCR_RST_DOZE;
      st_reg.span <= CCR_RST_SPAN;
      st_reg.span_bip <= CCR_RST_SPAN[0];
      st_reg.span_mv <= CCR_SPAN_MV[CCR_RST_SPAN[3:1]];
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs from flip-flops
  assign chan_start = st_reg.start;
  assign avg_valid = st_reg.avg_vld;
  assign avg_data = st_reg.avg_out;
  assign averaging_on = st_reg.avg_on;
  assign average_count_code = st_reg.avg_code;
  assign automatic_gain_ranging = st_reg.ranging;
  assign chan_doze = st_reg.doze;
  assign span_code = st_reg.span;
  assign span_bipolar = st_reg.span_bip;
  assign span_limit_mv = st_reg.span_mv;

  // Checks
  a_reset_values: assert property (@(posedge pclk) $rose(presetn) |->
    (st_reg.ranging == 8'hFF) && (st_reg.span == 4'hF) && !st_reg.avg_on && (st_reg.avg_code == 4'h0))
    else $error("register reset values wrong");

  a_avg_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_avg) |=> (averaging_on == $past(pwdata[7])))
    else $error("averaging enable not written");

  a_ratio_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_avg) |=> (average_count_code == $past(pwdata[3:0])))
    else $error("ratio field not written");

  a_ranging_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_rng) |=> (automatic_gain_ranging == $past(pwdata[7:0])))
    else $error("ranging enables not written");

  a_doze_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_doze) |=> (chan_doze == $past(pwdata[7:0])))
    else $error("doze bits not written");

  a_doze_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && conv_req) |=> (chan_start == ~$past(chan_doze)))
    else $error("conversion request gating wrong");

  a_passthru_avg: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !averaging_on && result_valid[3] && !(wr_en && hit_avg)) |=>
    (avg_valid[3] && (avg_data[3] == $past(result_data[3]))))
    else $error("pass-through result lost");

  a_two_avg: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && averaging_on && average_count_code == 4'h0 && st_reg.cnt[0] == 17'h0 && result_valid[0]
     && !(wr_en && hit_avg)) |=> !avg_valid[0])
    else $error("first of two results produced an output");

  a_avg_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_avg) |-> (prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0))
    else $error("reserved averaging bits not zero");

  a_span_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_span) |-> (prdata[31:4] == 28'h0))
    else $error("reserved span bits not zero");

  a_span_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_span && pwdata[3:0] == 4'h2) |=> (!span_bipolar && span_limit_mv == 16'h1388))
    else $error("span decode wrong");

  // Settings hold between their own writes
  a_ranging_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_rng) |=> $stable(automatic_gain_ranging))
    else $error("ranging enables changed without a write");

  a_doze_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_doze) |=> $stable(chan_doze))
    else $error("doze bits changed without a write");

  a_span_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_span) |=> $stable(span_code))
    else $error("span code changed without a write");

  a_avg_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && hit_avg) |=> ($stable(averaging_on) && $stable(average_count_code)))
    else $error("averaging settings changed without a write");

  a_freeze_outputs: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> ($stable(chan_start) && $stable(avg_valid) && $stable(avg_data)))
    else $error("outputs moved while frozen");

  // Span decode against the range table
  a_span_polarity: assert property (@(posedge pclk) disable iff (!presetn)
    span_bipolar == span_code[0])
    else $error("span polarity does not follow the code");

  a_span_low_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (span_code[3:1] == 3'h0) |-> (span_limit_mv == 16'h09C4))
    else $error("lowest span limit wrong");

  a_span_top_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (span_code[3:1] == 3'h7) |-> (span_limit_mv == 16'h9C40))
    else $error("widest span limit wrong");

  // Bus answers match the register levels
  a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && !mapped) |-> (prdata == 32'h0))
    else $error("unmapped read not zero");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr)
    else $error("unmapped access without error");

  a_mapped_okay: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && mapped) |-> !pslverr)
    else $error("mapped access flagged as error");

  a_rng_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_rng) |-> (prdata == {24'h0, automatic_gain_ranging}))
    else $error("ranging read-back wrong");

  a_doze_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_doze) |-> (prdata == {24'h0, chan_doze}))
    else $error("doze read-back wrong");

  a_avg_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_avg) |-> (prdata[7] == averaging_on && prdata[3:0] == average_count_code))
    else $error("averaging read-back wrong");

  a_span_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && hit_span) |-> (prdata[3:0] == span_code))
    else $error("span read-back wrong");

  // Request gating and averaging series
  a_idle_no_start: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !conv_req) |=> (chan_start == '0))
    else $error("start without a request");

  a_avg_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && (result_valid == '0)) |=> (avg_valid == '0))
    else $error("averaged output without a result");

  a_chan_indep: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && averaging_on && !result_valid[1] && !(wr_en && hit_avg)) |=> $stable(st_reg.cnt[1]))
    else $error("channel series moved without its own result");

  a_passthru_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !averaging_on) |=> (st_reg.cnt[2] == '0))
    else $error("series count kept while averaging is off");

  a_series_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_avg) |=> ((st_reg.cnt == '0) && (st_reg.acc == '0)))
    else $error("series not restarted on averaging write");

  a_avg_count_end: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && averaging_on && average_count_code == 4'h0 && st_reg.cnt[0] == CCR_CNTW'(1) && result_valid[0]
     && !(wr_en && hit_avg)) |=> avg_valid[0])
    else $error("second of two results gave no output");

  a_four_early: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && averaging_on && average_count_code == 4'h1 && st_reg.cnt[0] != CCR_CNTW'(3) && result_valid[0]
     && !(wr_en && hit_avg)) |=> !avg_valid[0])
    else $error("output before the fourth result");

  a_four_end: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && averaging_on && average_count_code == 4'h1 && st_reg.cnt[0] == CCR_CNTW'(3) && result_valid[0]
     && !(wr_en && hit_avg)) |=> avg_valid[0])
    else $error("fourth result gave no output");

endmodule : ccr_top

// ===== dv/ccr_top_bench.sv
// Purpose: Self-checking bench for the conversion configuration registers.
// Assumes: Zero-wait APB slave; clk_en held high except while the freeze test drives it low.
// Notes: Expected values are worked out here from the register map and span table.
`timescale 1ns/100ps
module ccr_top_bench
  import ccr_pkg::*;
;
  // Stimulus and observed signals
  logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_req = 1'b0;
  logic [CCR_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, averaging_on, span_bipolar;
  logic [CCR_NCH-1:0] result_valid = '0, chan_start, avg_valid, automatic_gain_ranging, chan_doze;
  logic [CCR_NCH-1:0][CCR_DW-1:0] result_data = '0, avg_data;
  logic [3:0] average_count_code, span_code;
  logic [15:0] span_limit_mv;
  int errors = 0, num_checks = 0;
  localparam logic [11:0] A_AVG = {CCR_IDX_AVG, 2'h0}, A_RNG = {CCR_IDX_RANGING, 2'h0};
  localparam logic [11:0] A_DOZ = {CCR_IDX_DOZE, 2'h0}, A_SPN = {CCR_IDX_SPAN, 2'h0};
  // Span limits in millivolts, widest pair first
  localparam logic [7:0][15:0] MV = {16'h9C40, 16'h61A8, 16'h4E20, 16'h30D4,
    16'h2710, 16'h186A, 16'h1388, 16'h09C4};

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  ccr_top ccr_top_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .conv_req, .result_valid, .result_data, .chan_start, .avg_valid, .avg_data, .averaging_on,
    .average_count_code, .automatic_gain_ranging, .chan_doze, .span_code, .span_bipolar, .span_limit_mv);

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error taken at the completing edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    #1;
  endtask : apb

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk

  task t_reset;
    rchk(A_AVG, 32'h00);
    rchk(A_RNG, 32'hFF);
    rchk(A_DOZ, 32'h00);
    rchk(A_SPN, 32'h0F);
    chk({span_bipolar, span_limit_mv}, 32'h19C40);
    $display("reset test done");
  endtask : t_reset

  // Reserved bits, read-back and an unmapped place
  task t_regs;
    apb(1'b1, A_AVG, 32'hFFFFFF7F);
    rchk(A_AVG, 32'h0F);
    chk({averaging_on, average_count_code}, 32'h0F);
    apb(1'b1, A_SPN, 32'hFFFFFFF3);
    rchk(A_SPN, 32'h03);
    apb(1'b1, A_RNG, 32'h5A);
    rchk(A_RNG, 32'h5A);
    chk(automatic_gain_ranging, 32'h5A);
    apb(1'b1, 12'h0AC, 32'hFF);
    chk(err, 32'h1);
    rchk(12'h0AC, 32'h0);
    apb(1'b1, A_AVG, 32'h0);
    $display("register test done");
  endtask : t_regs

  // Every span code decoded
  task t_span;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, A_SPN, c);
      @(posedge pclk);
      #1;
      chk({span_code, span_bipolar, span_limit_mv}, {c[3:0], c[0], MV[c>>1]});
    end
    $display("span test done");
  endtask : t_span

  // Dozing channels refuse a conversion request
  task t_doze;
    apb(1'b1, A_DOZ, 32'h5A);
    chk(chan_doze, 32'h5A);
    @(posedge pclk);
    conv_req <= 1'b1;
    @(posedge pclk);
    conv_req <= 1'b0;
    #1 chk(chan_start, 32'hA5);
    @(posedge pclk);
    #1 chk(chan_start, 32'h00);
    apb(1'b1, A_DOZ, 32'h0);
    $display("doze test done");
  endtask : t_doze

  // Feed a full series to every channel and check each average
  task avg_run(input logic on, input int code);
    int n;
    logic [15:0] v;
    logic [31:0] s [CCR_NCH];
    n = on ? (1 << (code + 1)) : 1;
    apb(1'b1, A_AVG, {28'h0, average_count_code});
    apb(1'b1, A_AVG, code);
    apb(1'b1, A_AVG, {24'h0, on, 3'h0, code[3:0]});
    chk(averaging_on, on);
    for (int i = 0; i < CCR_NCH; i++) s[i] = 0;
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      result_valid <= '1;
      for (int i = 0; i < CCR_NCH; i++) begin
        v = 16'h1000 * i + 16'h0123 * k + 16'h0001;
        result_data[i] <= v;
        s[i] += v;
      end
    end
    @(posedge pclk);
    result_valid <= '0;
    result_data <= ~result_data;
    #1;
    for (int i = 0; i < CCR_NCH; i++) begin
      chk(avg_valid[i], 32'h1);
      chk(avg_data[i], s[i] >> (on ? code + 1 : 0));
    end
    $display("averaging run done");
  endtask : avg_run

  // Clock enable low freezes every state bit
  task t_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    conv_req <= 1'b1;
    result_valid <= '1;
    repeat (2) @(posedge pclk);
    #1;
    chk(chan_start, 32'h00);
    chk(avg_valid, 32'h00);
    @(posedge pclk);
    clk_en <= 1'b1;
    conv_req <= 1'b0;
    result_valid <= '0;
    @(posedge pclk);
    #1 chk(chan_start, 32'h00);
    $display("freeze test done");
  endtask : t_freeze

  // Reset in mid-run restores every register
  task t_rerst;
    apb(1'b1, A_RNG, 32'h00);
    apb(1'b1, A_SPN, 32'h04);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk(automatic_gain_ranging, 32'hFF);
    chk(span_code, 32'h0F);
    rchk(A_RNG, 32'hFF);
    rchk(A_AVG, 32'h00);
    $display("mid-run reset test done");
  endtask : t_rerst

  task wrap_up;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_regs;
    t_span;
    t_doze;
    t_freeze;
    avg_run(1'b0, 0);
    avg_run(1'b1, 0);
    avg_run(1'b1, 1);
    avg_run(1'b1, 2);
    t_rerst;
    wrap_up;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up;
  end
endmodule : ccr_top_bench
